// >>> fwsc_top.sv
`include "fwsc_map.svh"
module fwsc_top #(
  parameter int ADDR_W = 16,
  parameter int PAGE_W = 6
) (
  input  wire logic              clock,             // System clock, 100 MHz.
  input  wire logic              rst_b,             // Asynchronous reset, active low.
  input  wire logic              sfrWr,             // Special function register write strobe.
  input  wire logic              sfrRd,             // Special function register read strobe.
  input  wire logic [7:0]        sfrAddr,           // Special function register address.
  input  wire logic [7:0]        sfrWdata,          // Special function register write data.
  output logic      [7:0]        sfrRdata,          // Read data, valid the cycle after sfrRd.
  input  wire logic              ioWr,              // I/O RAM write strobe.
  input  wire logic              ioRd,              // I/O RAM read strobe.
  input  wire logic [15:0]       ioAddr,            // I/O RAM address.
  input  wire logic [7:0]        ioWdata,           // I/O RAM write data.
  output logic      [7:0]        ioRdata,           // Read data, valid the cycle after ioRd.
  input  wire logic              intEnable,         // Global MPU interrupt enable.
  input  wire logic              movxWr,            // External move store of the accumulator.
  input  wire logic [ADDR_W-1:0] movxAddr,          // Data pointer of that store.
  input  wire logic [7:0]        movxData,          // Accumulator value of that store.
  output logic                   xramWr,            // External RAM write strobe.
  output logic      [ADDR_W-1:0] xramAddr,          // External RAM write address.
  output logic      [7:0]        xramData,          // External RAM write data.
  input  wire logic              securityLock,      // Flash security lock.
  input  wire logic              ceEnable,          // Compute engine enabled.
  input  wire logic              ceBusy,            // Compute engine busy.
  input  wire logic              debugPortEn,       // Debug port enabled.
  output logic                   extReadPermitted,  // Debug or SPI port may read flash.
  output logic                   extWritePermitted, // Debug or SPI port may write flash.
  output logic                   flashWrStb,        // Program one flash byte.
  output logic      [ADDR_W-1:0] flashWrAddr,       // Flash byte address.
  output logic      [7:0]        flashWrData,       // Flash byte value.
  output logic                   pageEraseStb,      // Start a page erase.
  output logic      [PAGE_W-1:0] pageEraseSel,      // Page to erase.
  output logic                   massEraseStb       // Start a mass erase.
);
  logic              pweReg, pweNext, meenReg, meenNext, pstwrReg, pageArmReg, pageArmNext;
  logic [3:0]        keyReg;
  logic [PAGE_W-1:0] pageSelReg;
  logic              pageStbReg, massStbReg, xramWrReg;
  logic [ADDR_W-1:0] xramAddrReg;
  logic [7:0]        xramDataReg, sfrRdReg, ioRdReg;

  fwsc_flash_if #(.ADDR_W(ADDR_W)) fq ();

  function automatic logic sfrHit(input logic stb, input logic [7:0] a, input logic [7:0] ofs);
    sfrHit = stb && (a == ofs);
  endfunction

  wire ctrlWr   = sfrHit(sfrWr, sfrAddr, `FWSC_SFR_CTRL);
  wire eraseWr  = sfrHit(sfrWr, sfrAddr, `FWSC_SFR_ERASE);
  wire pageWr   = sfrHit(sfrWr, sfrAddr, `FWSC_SFR_PAGE);
  wire keyWr    = ioWr && (ioAddr == `FWSC_IO_SEC);
  wire keyOk    = (keyReg == `FWSC_KEY_OPEN);
  wire storeHit = movxWr && pweReg;
  // Mass erase needs the arm bit, page erase a page write; a rejected erase write leaves either arm set for a later attempt.
  wire massGo   = eraseWr && (sfrWdata == `FWSC_ERASE_MASS) && keyOk
                  && meenReg && debugPortEn;
  wire pageGo   = eraseWr && (sfrWdata == `FWSC_ERASE_PAGE) && keyOk && pageArmReg;

  // The byte-store clear takes priority, so a bit write in the same cycle cannot re-arm.
  assign pweNext     = storeHit ? 1'h0 :
                       (ctrlWr && !intEnable) ? sfrWdata[`FWSC_B_PWE] : pweReg;
  assign meenNext    = massGo ? 1'h0 : ctrlWr ? sfrWdata[`FWSC_B_MEEN] : meenReg;
  assign pageArmNext = pageWr ? 1'h1 : pageGo ? 1'h0 : pageArmReg;

  assign fq.reqValid = storeHit && keyOk;
  assign fq.reqAddr  = movxAddr;
  assign fq.reqData  = movxData;
  assign fq.postMode = pstwrReg && ceEnable;
  assign fq.ceBusy   = ceBusy;

  fwsc_post_queue #(.ADDR_W(ADDR_W)) u_queue (
    .clock (clock),
    .rst_b (rst_b),
    .fq    (fq)
  );

  // The read views are built from named bit positions, so the map lives in one header.
  logic [7:0]        ctrlView, secView;

  always_comb begin
    ctrlView                = `FWSC_RST_BYTE;
    ctrlView[`FWSC_B_PWE]   = pweReg;
    ctrlView[`FWSC_B_PSTWR] = pstwrReg;
    ctrlView[`FWSC_B_PEND]  = fq.pending;
  end

  always_comb begin
    secView                            = `FWSC_RST_BYTE;
    secView[`FWSC_KEY_HI:`FWSC_KEY_LO] = keyReg;
    secView[`FWSC_B_RDE]               = extReadPermitted;
    secView[`FWSC_B_WRE]               = extWritePermitted;
  end

  wire [7:0] sfrView = (sfrAddr == `FWSC_SFR_CTRL) ? ctrlView : `FWSC_RST_BYTE;
  wire [7:0] ioView  = (ioAddr == `FWSC_IO_SEC) ? secView : `FWSC_RST_BYTE;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pweReg     <= `FWSC_RST_BIT;
      meenReg    <= `FWSC_RST_BIT;
      pageArmReg <= `FWSC_RST_BIT;
    end else begin
      pweReg     <= pweNext;
      meenReg    <= meenNext;
      pageArmReg <= pageArmNext;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pstwrReg   <= `FWSC_RST_BIT;
      keyReg     <= `FWSC_RST_KEY;
      pageSelReg <= '0;
    end else begin
      if (ctrlWr) pstwrReg <= sfrWdata[`FWSC_B_PSTWR];
      if (keyWr) keyReg <= ioWdata[`FWSC_KEY_HI:`FWSC_KEY_LO];
      if (pageWr) pageSelReg <= sfrWdata[`FWSC_PAGE_HI:`FWSC_PAGE_LO];
    end
  end

  // Erase strobes are registered, so each accepted pattern write gives exactly one pulse.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pageStbReg <= `FWSC_RST_BIT;
      massStbReg <= `FWSC_RST_BIT;
    end else begin
      pageStbReg <= pageGo;
      massStbReg <= massGo;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      xramWrReg   <= `FWSC_RST_BIT;
      xramAddrReg <= '0;
      xramDataReg <= `FWSC_RST_BYTE;
    end else begin
      xramWrReg <= movxWr && !pweReg;
      if (movxWr && !pweReg) begin
        xramAddrReg <= movxAddr;
        xramDataReg <= movxData;
      end
    end
  end

  // Reads have no side effects; the view is captured once per strobe and then held.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdReg <= `FWSC_RST_BYTE;
      ioRdReg  <= `FWSC_RST_BYTE;
    end else begin
      if (sfrRd) sfrRdReg <= sfrView;
      if (ioRd) ioRdReg <= ioView;
    end
  end

  assign extReadPermitted  = !securityLock;
  // Port writes also need the open key, so an unkeyed part refuses external programming.
  assign extWritePermitted = !securityLock && keyOk;
  assign sfrRdata     = sfrRdReg;
  assign ioRdata      = ioRdReg;
  assign xramWr       = xramWrReg;
  assign xramAddr     = xramAddrReg;
  assign xramData     = xramDataReg;
  assign flashWrStb   = fq.wrStb;
  assign flashWrAddr  = fq.wrAddr;
  assign flashWrData  = fq.wrData;
  assign pageEraseStb = pageStbReg;
  assign pageEraseSel = pageSelReg;
  assign massEraseStb = massStbReg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_xram_normal_path: assert property (
    movxWr && !pweReg |=> xramWr && xramAddr == $past(movxAddr)
    && (!flashWrStb || $past(fq.pending)))
    else $error("normal store did not reach external RAM");
  a_store_to_flash: assert property (
    movxWr && pweReg && keyOk && !fq.pending && !fq.postMode
    |=> flashWrStb && flashWrAddr == $past(movxAddr) && !xramWr)
    else $error("enabled store did not program flash");
  a_pwe_self_clear: assert property (movxWr && pweReg |=> !pweReg)
    else $error("write enable survived a byte store");
  a_pwe_int_lock: assert property (
    ctrlWr && intEnable && !movxWr |=> pweReg == $past(pweReg))
    else $error("write enable changed while interrupts enabled");
  a_read_permit_inv: assert property (extReadPermitted != securityLock)
    else $error("read permission does not follow the lock");
  a_write_permit_key: assert property (extWritePermitted |-> keyOk && !securityLock)
    else $error("write permission without key");
  a_erase_key_gate: assert property (
    eraseWr && !keyOk |=> !pageEraseStb && !massEraseStb)
    else $error("erase started with a wrong key");
  a_mass_erase_arm: assert property (
    massEraseStb |-> $past(meenReg) && $past(debugPortEn) && !meenReg)
    else $error("mass erase without arm or debug port");
  a_page_erase_once: assert property (
    pageEraseStb |-> !pageArmReg ##1 !pageEraseStb)
    else $error("page erase arm not consumed");
  a_bad_key_store: assert property (
    movxWr && pweReg && !keyOk && !fq.pending |=> !flashWrStb && !pweReg)
    else $error("store with wrong key touched flash");
  a_store_skips_ram: assert property (movxWr && pweReg |=> !xramWr)
    else $error("enabled store also wrote external RAM");
  a_pend_readback: assert property (
    sfrRd && sfrAddr == `FWSC_SFR_CTRL |=> sfrRdata[`FWSC_B_PEND] == $past(fq.pending))
    else $error("pending bit read back wrong");
  a_key_read_back: assert property (
    ioRd && ioAddr == `FWSC_IO_SEC |=> ioRdata[`FWSC_KEY_HI:`FWSC_KEY_LO] == $past(keyReg))
    else $error("modify key read back wrong");
  a_page_arm_need: assert property (
    pageEraseStb |-> $past(pageArmReg) && $past(keyOk))
    else $error("page erase without fresh page select or key");

  // Coverage of the main flows: a flash byte, both erase kinds and a plain RAM store.
  c_flash_byte: cover property (storeHit && keyOk ##1 flashWrStb);
  c_mass_erase: cover property (massEraseStb);
  c_page_erase: cover property (pageEraseStb);
  c_xram_store: cover property (xramWr);
endmodule

// >>> fwsc_map.svh
`ifndef FWSC_MAP_SVH
`define FWSC_MAP_SVH

`define FWSC_SFR_CTRL    8'hB2
`define FWSC_SFR_ERASE   8'h94
`define FWSC_SFR_PAGE    8'hB7
`define FWSC_IO_SEC      16'h2702

`define FWSC_B_PWE       0
`define FWSC_B_MEEN      1
`define FWSC_B_PSTWR     2
`define FWSC_B_PEND      3
`define FWSC_PAGE_HI     7
`define FWSC_PAGE_LO     2
`define FWSC_KEY_HI      7
`define FWSC_KEY_LO      4
`define FWSC_B_RDE       2
`define FWSC_B_WRE       1

`define FWSC_KEY_OPEN    4'h2
`define FWSC_ERASE_PAGE  8'h55
`define FWSC_ERASE_MASS  8'hAA

`define FWSC_RST_BIT     1'h0
`define FWSC_RST_KEY     4'h0
`define FWSC_RST_BYTE    8'h00

`endif

// >>> fwsc_pkg.sv
package fwsc_pkg;
  typedef enum logic [0:0] {
    Q_EMPTY = 1'h0,
    Q_HELD  = 1'h1
  } fwsc_q_e;
endpackage

// >>> fwsc_flash_if.sv
interface fwsc_flash_if #(parameter int ADDR_W = 16);
  logic              reqValid;
  logic [ADDR_W-1:0] reqAddr;
  logic [7:0]        reqData;
  logic              postMode;
  logic              ceBusy;
  logic              pending;
  logic              wrStb;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0]        wrData;
  modport ctrl  (output reqValid, reqAddr, reqData, postMode, ceBusy,
                 input  pending, wrStb, wrAddr, wrData);
  modport queue (input  reqValid, reqAddr, reqData, postMode, ceBusy,
                 output pending, wrStb, wrAddr, wrData);
endinterface

// >>> fwsc_post_queue.sv
`include "fwsc_map.svh"
module fwsc_post_queue #(
  parameter int ADDR_W = 16
) (
  input  wire logic   clock,   // System clock.
  input  wire logic   rst_b,   // Asynchronous reset, active low.
  fwsc_flash_if.queue fq       // Write requests in, flash strobes out.
);
  fwsc_pkg::fwsc_q_e stateReg, stateNext;
  logic              busyPrevReg;
  logic              wrStbReg;
  logic [ADDR_W-1:0] wrAddrReg, holdAddrReg;
  logic [7:0]        wrDataReg, holdDataReg;

  wire held       = (stateReg == fwsc_pkg::Q_HELD);
  wire busyFell   = busyPrevReg && !fq.ceBusy;
  wire acceptNow  = fq.reqValid && !held && !fq.postMode;
  wire acceptPost = fq.reqValid && !held && fq.postMode;
  // Dropping out of posted mode flushes the held byte rather than stranding it.
  wire fire       = held && (busyFell || !fq.postMode);

  always_comb begin
    unique case (stateReg)
      fwsc_pkg::Q_EMPTY: stateNext = acceptPost ? fwsc_pkg::Q_HELD : fwsc_pkg::Q_EMPTY;
      fwsc_pkg::Q_HELD:  stateNext = fire ? fwsc_pkg::Q_EMPTY : fwsc_pkg::Q_HELD;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stateReg    <= fwsc_pkg::Q_EMPTY;
      busyPrevReg <= `FWSC_RST_BIT;
      wrStbReg    <= `FWSC_RST_BIT;
      wrAddrReg   <= '0;
      wrDataReg   <= `FWSC_RST_BYTE;
      holdAddrReg <= '0;
      holdDataReg <= `FWSC_RST_BYTE;
    end else begin
      stateReg    <= stateNext;
      busyPrevReg <= fq.ceBusy;
      wrStbReg    <= acceptNow || fire;
      if (fire) begin
        wrAddrReg <= holdAddrReg;
        wrDataReg <= holdDataReg;
      end else if (acceptNow) begin
        wrAddrReg <= fq.reqAddr;
        wrDataReg <= fq.reqData;
      end
      if (acceptPost) begin
        holdAddrReg <= fq.reqAddr;
        holdDataReg <= fq.reqData;
      end
    end
  end

  assign fq.pending = held;
  assign fq.wrStb   = wrStbReg;
  assign fq.wrAddr  = wrAddrReg;
  assign fq.wrData  = wrDataReg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_post_hold_req: assert property (acceptPost |=> held && !wrStbReg)
    else $error("posted write was not held");
  a_post_fire_fall: assert property (
    held && fq.postMode && busyFell |=> wrStbReg && wrAddrReg == $past(holdAddrReg))
    else $error("held write did not run when busy fell");
  a_pend_ignore_req: assert property (
    held && fq.reqValid |=> holdAddrReg == $past(holdAddrReg))
    else $error("request accepted while a write was pending");
  a_immediate_write: assert property (
    !held && fq.reqValid && !fq.postMode |=> wrStbReg && wrDataReg == $past(fq.reqData))
    else $error("immediate write did not strobe next cycle");
  c_posted_flow: cover property (acceptPost ##[1:50] fire);
endmodule

// >>> fwsc_flash_model.sv
module fwsc_flash_model (
  input wire logic        clock,   // System clock.
  input wire logic        wrStb,   // Program one byte.
  input wire logic [15:0] wrAddr,  // Byte address.
  input wire logic [7:0]  wrData,  // Byte value.
  input wire logic        massStb  // Mass erase.
);
  timeunit 1ns;
  timeprecision 1ps;
  // Only the low address byte is kept; the bench never needs more.
  logic [7:0] mem [0:255];
  initial mem = '{default: 8'hFF};
  always @(posedge clock) begin
    if (massStb === 1'b1) mem <= '{default: 8'hFF};
    else if (wrStb === 1'b1) mem[wrAddr[7:0]] <= wrData;
  end
endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_b, sfrWr, sfrRd, ioWr, ioRd, intEnable, movxWr;
  logic        securityLock, ceEnable, ceBusy, debugPortEn;
  logic [7:0]  sfrAddr, sfrWdata, ioWdata, movxData, d, old;
  logic [15:0] ioAddr, movxAddr, a;
  logic [5:0]  expSel;
  wire  [7:0]  sfrRdata, ioRdata, xramData, flashWrData;
  wire  [15:0] xramAddr, flashWrAddr;
  wire  [5:0]  pageEraseSel;
  wire         xramWr, extReadPermitted, extWritePermitted;
  wire         flashWrStb, pageEraseStb, massEraseStb;
  int          fails, check_count, pageSeen, massSeen, expPage, expMass;
  logic [23:0] expFlash[$], expXram[$];
  logic [7:0]  pat [7] = '{8'h55, 8'h55, 8'hAA, 8'hAA, 8'hAA, 8'h3C, 8'h55};
  // Case bits: 3 wrong key, 2 debug port on, 1 mass arm written, 0 page written.
  logic [3:0]  cfg [7] = '{4'h5, 4'h4, 4'h6, 4'h4, 4'h2, 4'h7, 4'hD};

  fwsc_top u_dut (.clock, .rst_b, .sfrWr, .sfrRd, .sfrAddr, .sfrWdata, .sfrRdata,
    .ioWr, .ioRd, .ioAddr, .ioWdata, .ioRdata, .intEnable, .movxWr, .movxAddr,
    .movxData, .xramWr, .xramAddr, .xramData, .securityLock, .ceEnable, .ceBusy,
    .debugPortEn, .extReadPermitted, .extWritePermitted, .flashWrStb, .flashWrAddr,
    .flashWrData, .pageEraseStb, .pageEraseSel, .massEraseStb);
  fwsc_flash_model u_flash (.clock, .wrStb(flashWrStb), .wrAddr(flashWrAddr),
    .wrData(flashWrData), .massStb(massEraseStb));

  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic busW(bit io, logic [15:0] ad, logic [7:0] wd);
    @(posedge clock);
    sfrWr <= !io;
    ioWr <= io;
    sfrAddr <= ad[7:0];
    ioAddr <= ad;
    sfrWdata <= wd;
    ioWdata <= wd;
    @(posedge clock);
    sfrWr <= 1'b0;
    ioWr <= 1'b0;
  endtask
  task automatic busR(bit io, logic [15:0] ad, logic [7:0] ex, string nm);
    @(posedge clock);
    sfrRd <= !io;
    ioRd <= io;
    sfrAddr <= ad[7:0];
    ioAddr <= ad;
    @(posedge clock);
    sfrRd <= 1'b0;
    ioRd <= 1'b0;
    #1 chk(nm, {16'h0000, ex}, {16'h0000, io ? ioRdata : sfrRdata});
  endtask
  task automatic store(logic [15:0] ad, logic [7:0] dv);
    @(posedge clock);
    movxWr <= 1'b1;
    movxAddr <= ad;
    movxData <= dv;
    @(posedge clock);
    movxWr <= 1'b0;
  endtask
  task automatic finishTest(string nm);
    repeat (4) @(posedge clock);
    chk("flash queue", 24'h0, 24'(expFlash.size()));
    chk("ram queue", 24'h0, 24'(expXram.size()));
    $display("test %s done", nm);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Each flash and RAM strobe is matched against the bench queues, so an extra strobe also fails.
  always @(posedge clock) begin
    if (flashWrStb === 1'b1) begin
      chk("flash strobe", 24'h1, 24'(expFlash.size() != 0));
      if (expFlash.size() != 0) chk("flash byte", expFlash.pop_front(), {flashWrAddr, flashWrData});
    end
    if (xramWr === 1'b1) begin
      chk("ram strobe", 24'h1, 24'(expXram.size() != 0));
      if (expXram.size() != 0) chk("ram byte", expXram.pop_front(), {xramAddr, xramData});
    end
    if (pageEraseStb === 1'b1) begin
      pageSeen++;
      chk("page select", {18'h0, expSel}, {18'h0, pageEraseSel});
    end
    if (massEraseStb === 1'b1) massSeen++;
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    {rst_b, sfrWr, sfrRd, ioWr, ioRd, intEnable, movxWr} = '0;
    {securityLock, ceEnable, ceBusy, debugPortEn} = '0;
    {sfrAddr, sfrWdata, ioWdata, movxData, ioAddr, movxAddr, expSel} = '0;
    void'($urandom(32'h0A8C8D25));
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    busR(0, 16'h00B2, 8'h00, "control reset");
    busR(1, 16'h2702, 8'h04, "security reset");
    busR(1, 16'h2700, 8'h00, "unmapped");
    busR(0, 16'h0094, 8'h00, "erase read");
    for (int i = 0; i < 3; i++) begin
      securityLock <= (i == 1);
      busW(1, 16'h2702, i == 0 ? 8'h30 : 8'h20);
      busR(1, 16'h2702, i == 0 ? 8'h34 : (i == 1 ? 8'h20 : 8'h26), "key flags");
      chk("read permit", 24'(i != 1), 24'(extReadPermitted));
      chk("write permit", 24'(i == 2), 24'(extWritePermitted));
    end
    finishTest("security");
    a = 16'($urandom);
    d = 8'($urandom);
    expXram.push_back({a, d});
    store(a, d);
    finishTest("ram store");
    for (int i = 0; i < 3; i++) begin
      busW(0, 16'h00B2, 8'h01);
      a = 16'($urandom);
      d = 8'($urandom);
      expFlash.push_back({a, d});
      store(a, d);
      busR(0, 16'h00B2, 8'h00, "enable cleared");
      chk("flash content", {16'h0, d}, {16'h0, u_flash.mem[a[7:0]]});
    end
    expXram.push_back({a, d});
    store(a, d);
    finishTest("byte program");
    intEnable <= 1'b1;
    busW(0, 16'h00B2, 8'h05);
    busR(0, 16'h00B2, 8'h04, "locked enable");
    intEnable <= 1'b0;
    busW(0, 16'h00B2, 8'h00);
    expXram.push_back({a, d});
    store(a, d);
    finishTest("interrupt lock");
    busW(1, 16'h2702, 8'h30);
    busW(0, 16'h00B2, 8'h01);
    old = u_flash.mem[a[7:0]];
    store(a, ~old);
    busR(0, 16'h00B2, 8'h00, "bad key clear");
    chk("flash kept", {16'h0, old}, {16'h0, u_flash.mem[a[7:0]]});
    busW(1, 16'h2702, 8'h20);
    finishTest("wrong key");
    ceEnable <= 1'b1;
    ceBusy <= 1'b1;
    busW(0, 16'h00B2, 8'h05);
    a = 16'($urandom);
    d = 8'($urandom);
    expFlash.push_back({a, d});
    store(a, d);
    busR(0, 16'h00B2, 8'h0C, "pending");
    busW(0, 16'h00B2, 8'h05);
    store(~a, ~d);
    repeat (3) @(posedge clock);
    chk("held write", 24'h1, 24'(expFlash.size()));
    ceBusy <= 1'b0;
    finishTest("posted write");
    busW(0, 16'h00B2, 8'h00);
    ceEnable <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      debugPortEn <= cfg[i][2];
      busW(1, 16'h2702, cfg[i][3] ? 8'h30 : 8'h20);
      if (cfg[i][0]) begin
        expSel = 6'($urandom);
        busW(0, 16'h00B7, {expSel, 2'b00});
      end
      if (cfg[i][1]) busW(0, 16'h00B2, 8'h02);
      busW(0, 16'h0094, pat[i]);
      expPage += int'(pat[i] == 8'h55 && cfg[i][0] && !cfg[i][3]);
      expMass += int'(pat[i] == 8'hAA && cfg[i][1] && cfg[i][2] && !cfg[i][3]);
      repeat (3) @(posedge clock);
      chk("page erases", 24'(expPage), 24'(pageSeen));
      chk("mass erases", 24'(expMass), 24'(massSeen));
    end
    finishTest("erase");
    give_verdict();
  end
endmodule
